// File: src/spp_pkg.sv
// Package for the sector persistent protection block: register map, fields, timing
package spp_pkg;

    // Geometry with the top/bottom setting at 0
    localparam int NUM_BLOCKS      = 254;
    localparam int NUM_TOP_SECTORS = 32;
    localparam int NUM_BITS        = 286;
    localparam int IDX_W           = 9;
    localparam logic [IDX_W-1:0] TOP_SECTOR_BASE_IDX = 9'h0FE;
    localparam logic [23:0] TOP_REGION_BASE_ADDR = 24'hFE0000;

    // Register byte offsets
    localparam logic [7:0] REG_CMD     = 8'h00;
    localparam logic [7:0] REG_ADDR    = 8'h04;
    localparam logic [7:0] REG_STATUS  = 8'h08;
    localparam logic [7:0] REG_RDATA   = 8'h0C;
    localparam logic [7:0] REG_DYN     = 8'h10;
    localparam logic [7:0] REG_ARRAYRD = 8'h14;

    // Command codes written to the command register
    localparam logic [2:0] CMD_PROG     = 3'h1;
    localparam logic [2:0] CMD_ERASE    = 3'h2;
    localparam logic [2:0] CMD_READ     = 3'h3;
    localparam logic [2:0] CMD_LOCK     = 3'h4;
    localparam logic [2:0] CMD_ARRAYCHK = 3'h5;

    // Status register field positions
    localparam int ST_BUSY    = 0;
    localparam int ST_FAIL    = 1;
    localparam int ST_LOCK    = 2;
    localparam int ST_RVALID  = 3;
    localparam int ST_ARRBLK  = 4;

    // Reset values
    localparam logic PPB_ERASED_VAL = 1'b1;
    localparam logic LOCK_RESET_VAL = 1'b1;

    // Timing, in microseconds and nanoseconds, and derived cycle counts at 125 MHz
    localparam int CLK_MHZ          = 125;
    localparam int PAGE_PROG_US     = 200;
    localparam int SECTOR_ERASE_US  = 45000;
    localparam int INIT_ACCESS_NS   = 40;
    localparam int PROG_CYCLES      = PAGE_PROG_US * CLK_MHZ;
    localparam int ERASE_CYCLES     = SECTOR_ERASE_US * CLK_MHZ;
    localparam int ACCESS_CYCLES    = (INIT_ACCESS_NS * CLK_MHZ + 999) / 1000;

    // AHB-Lite request captured in the address phase
    typedef struct packed {
        logic       valid;
        logic       write;
        logic [7:0] addr;
    } spp_req_s;

    // Operation under way
    typedef enum logic [1:0] {
        SPP_OP_NONE,
        SPP_OP_PROG,
        SPP_OP_ERASE
    } spp_op_e;

endpackage : spp_pkg

// File: src/spp_timer.sv
// Busy timer: counts down a loaded cycle count and pulses when done
`timescale 1ns/100ps
module spp_timer #(
    parameter int CNT_W = 24
) (
    // Clock and reset
    input  wire logic             hclk,
    input  wire logic             hresetn,
    // Control
    input  wire logic             start,
    input  wire logic [CNT_W-1:0] load,
    // Status
    output logic                  running,
    output logic                  done
);
    logic [CNT_W-1:0] count;

    // Count down; done is a one-cycle pulse when the count runs out
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            count   <= '0;
            running <= 1'b0;
            done    <= 1'b0;
        end
        else
        begin
            done <= 1'b0;
            if (start && !running)
            begin
                count   <= load;
                running <= 1'b1;
            end
            else if (running)
            begin
                if (count <= 1)
                begin
                    running <= 1'b0;
                    done    <= 1'b1;
                end
                count <= count - 1'b1;
            end
        end
    end

endmodule : spp_timer

// File: src/spp_core.sv
// Persistent protection bit store with AHB-Lite register access
`timescale 1ns/100ps
// Operation
// - Blocks 0-253 own bits 0-253; top 32 sectors own bits 254-285.
// - Bits are non-volatile; program singly, erase only as a group.
// - Program drives one bit to 0; erase sets every bit to 1.
// - No single-bit erase; group erase ignores any supplied address.
// - Device runs erase preprogram and verify itself; host only polls.
// - Busy lasts a page-program time for program, sector-erase for erase.
// - Status register reports busy throughout program and erase.
// - Bit read waits the ordinary initial array access latency.
// - Array reads are refused while a bit program is under way.
// - A read command returns the addressed region's persistent bit.
// - After delivery every bit reads 1, all regions unprotected.
// - Lock bit at 0 makes program and erase fail, bits unchanged.
// - Region is write-protected when either persistent or dynamic bit is 0.
module spp_core
    import spp_pkg::*;
#(
    parameter int PROG_CNT  = PROG_CYCLES,
    parameter int ERASE_CNT = ERASE_CYCLES
) (
    // AHB-Lite slave
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Protection result for the addressed region
    output logic             region_protected
);
    import spp_pkg::*;

    logic [NUM_BITS-1:0] persistent_prot_bit;        // persistent_prot_bit store
    logic [NUM_BITS-1:0] dynamic_prot_bit;        // dynamic_prot_bit store
    logic                lock_bit;   // persistent_lock_bit
    logic [23:0]         addr_reg;
    spp_req_s            req;
    spp_op_e             op;
    logic [IDX_W-1:0]    op_idx;
    logic                fail;
    logic                rvalid;
    logic                rbit;
    logic                arr_blocked;
    logic [3:0]          acc_cnt;
    logic                acc_busy;
    logic                t_start;
    logic [23:0]         t_load;
    logic                t_running;
    logic                t_done;
    logic [2:0]          cmd;
    logic                wr_cmd;

    // Map a 24-bit address onto its bit index
    function automatic logic [IDX_W-1:0] region_idx(input logic [23:0] a);
        if (a >= TOP_REGION_BASE_ADDR)
            region_idx = TOP_SECTOR_BASE_IDX + IDX_W'(a[15:12]) + IDX_W'({a[16], 4'h0});
        else
            region_idx = IDX_W'(a[23:16]);
    endfunction : region_idx

    assign wr_cmd = req.valid && req.write && req.addr == REG_CMD;
    assign cmd    = hwdata[2:0];

    // Address phase capture; the slave never inserts wait states
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            req <= '0;
        else if (hready)
            req <= '{valid: hsel && htrans[1], write: hwrite, addr: haddr[7:0]};
    end

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // Address and dynamic bits written by software
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            addr_reg <= '0;
            dynamic_prot_bit      <= {NUM_BITS{1'b1}};
        end
        else if (req.valid && req.write)
        begin
            if (req.addr == REG_ADDR)
                addr_reg <= hwdata[23:0];
            if (req.addr == REG_DYN)
                dynamic_prot_bit[region_idx(addr_reg)] <= hwdata[0];
        end
    end

    // Lock bit: set at reset, only cleared by software
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            lock_bit <= LOCK_RESET_VAL;
        else if (wr_cmd && cmd == CMD_LOCK)
            lock_bit <= 1'b0;
    end

    // Operation start, busy tracking and failure flag
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            op     <= SPP_OP_NONE;
            op_idx <= '0;
            fail   <= 1'b0;
        end
        else if (t_done)
            op <= SPP_OP_NONE;
        else if (wr_cmd && op == SPP_OP_NONE && (cmd == CMD_PROG || cmd == CMD_ERASE))
        begin
            if (!lock_bit)
                fail <= 1'b1;
            else
            begin
                fail   <= 1'b0;
                op     <= (cmd == CMD_PROG) ? SPP_OP_PROG : SPP_OP_ERASE;
                op_idx <= region_idx(addr_reg);
            end
        end
    end

    assign t_start = wr_cmd && op == SPP_OP_NONE && lock_bit && (cmd == CMD_PROG || cmd == CMD_ERASE);
    assign t_load  = (cmd == CMD_PROG) ? 24'(PROG_CNT) : 24'(ERASE_CNT);

    spp_timer #(.CNT_W(24)) u_timer (
        .hclk    (hclk),
        .hresetn (hresetn),
        .start   (t_start),
        .load    (t_load),
        .running (t_running),
        .done    (t_done)
    );

    // Non-volatile store; the internal preprogram/verify is hidden in the erase time
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            persistent_prot_bit <= {NUM_BITS{PPB_ERASED_VAL}};
        else if (t_done && op == SPP_OP_PROG)
            persistent_prot_bit[op_idx] <= 1'b0;
        else if (t_done && op == SPP_OP_ERASE)
            persistent_prot_bit <= {NUM_BITS{1'b1}};
    end

    // Bit read with the initial access latency; array access check
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            acc_cnt     <= '0;
            acc_busy    <= 1'b0;
            rvalid      <= 1'b0;
            rbit        <= 1'b1;
            arr_blocked <= 1'b0;
        end
        else if (wr_cmd && cmd == CMD_READ)
        begin
            acc_cnt  <= 4'(ACCESS_CYCLES);
            acc_busy <= 1'b1;
            rvalid   <= 1'b0;
        end
        else if (acc_busy)
        begin
            acc_cnt <= acc_cnt - 1'b1;
            if (acc_cnt <= 1)
            begin
                acc_busy <= 1'b0;
                rvalid   <= 1'b1;
                rbit     <= persistent_prot_bit[region_idx(addr_reg)];
            end
        end
        else if (wr_cmd && cmd == CMD_ARRAYCHK)
            arr_blocked <= (op == SPP_OP_PROG);
    end

    // Protection result for the addressed region
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            region_protected <= 1'b0;
        else
            region_protected <= !persistent_prot_bit[region_idx(addr_reg)] || !dynamic_prot_bit[region_idx(addr_reg)];
    end

    // Read data mux for the data phase
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hrdata <= '0;
        else if (hready && hsel && htrans[1] && !hwrite)
        begin
            unique case (haddr[7:0])
                REG_ADDR:    hrdata <= {8'h00, addr_reg};
                REG_STATUS:  hrdata <= {27'h0, arr_blocked, rvalid, lock_bit, fail, op != SPP_OP_NONE};
                REG_RDATA:   hrdata <= {31'h0, rbit};
                REG_DYN:     hrdata <= {31'h0, dynamic_prot_bit[region_idx(addr_reg)]};
                REG_ARRAYRD: hrdata <= {31'h0, op == SPP_OP_PROG};
                default:     hrdata <= '0;
            endcase
        end
    end

    // Busy must hold for at least 8 cycles after a program starts
    AST_BUSY_PROG: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(op == SPP_OP_PROG) |-> (op == SPP_OP_PROG)[*8]) else $error("program busy dropped early");
    AST_LOCK_FAIL: assert property (@(posedge hclk) disable iff (!hresetn)
        (wr_cmd && !lock_bit && cmd == CMD_PROG && op == SPP_OP_NONE) |=> fail && op == SPP_OP_NONE)
        else $error("locked program not failed");
    AST_ERASE_ALL: assert property (@(posedge hclk) disable iff (!hresetn)
        (t_done && op == SPP_OP_ERASE) |=> &persistent_prot_bit) else $error("erase left bits at 0");
    AST_PROG_ONE: assert property (@(posedge hclk) disable iff (!hresetn)
        (t_done && op == SPP_OP_PROG) |=> !persistent_prot_bit[$past(op_idx)]) else $error("program missed bit");
    AST_STABLE: assert property (@(posedge hclk) disable iff (!hresetn)
        !t_done |=> persistent_prot_bit == $past(persistent_prot_bit)) else $error("bits changed without operation");
    AST_IGNORE_BUSY: assert property (@(posedge hclk) disable iff (!hresetn)
        (op != SPP_OP_NONE && !t_done) |=> $stable(op_idx)) else $error("command taken while busy");
    AST_READ_LAT: assert property (@(posedge hclk) disable iff (!hresetn)
        (wr_cmd && cmd == CMD_READ) |=> !rvalid ##[1:16] rvalid) else $error("read latency wrong");
    AST_STATUS_BUSY: assert property (@(posedge hclk) disable iff (!hresetn)
        t_running |-> op != SPP_OP_NONE) else $error("busy not reported");
    COV_PROG: cover property (@(posedge hclk) t_done && op == SPP_OP_PROG);
    COV_ERASE: cover property (@(posedge hclk) t_done && op == SPP_OP_ERASE);
    COV_LOCKED: cover property (@(posedge hclk) wr_cmd && cmd == CMD_PROG && !lock_bit);

endmodule : spp_core

// File: testbench/spp_host.sv
// AHB-Lite master model standing in for the protection-bit host
`timescale 1ns/100ps
module spp_host (
    // Bus clock
    input  wire logic        hclk,
    // Bus response
    input  wire logic        hready,
    input  wire logic [31:0] hrdata,
    // Bus request
    output logic             hsel,
    output logic [31:0]      haddr,
    output logic [1:0]       htrans,
    output logic             hwrite,
    output logic [2:0]       hsize,
    output logic [31:0]      hwdata
);
    // Bus idle at time zero
    initial
    begin
        hsel   = 1'b0;
        haddr  = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize  = 3'h2;
        hwdata = 32'h0;
    end

    // Region start address: offset zero, unused high bits zero
    function automatic logic [31:0] region_base(input int idx);
        if (idx < 254)
            return {8'h00, 8'(idx), 16'h0000};
        return 32'h00FE0000 + 32'(idx - 254) * 32'h1000;
    endfunction : region_base

    // One single word transfer; waits on hready, never on a cycle count
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        hwdata <= ~hwdata;  // Stale data must not look valid
        @(posedge hclk);
        while (!hready) @(posedge hclk);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (!hready) @(posedge hclk);
        q = hrdata;
    endtask : xfer
endmodule : spp_host

// File: testbench/sector_persistent_protection_test.sv
// Self-checking bench for the persistent protection bit store
`timescale 1ns/100ps
module sector_persistent_protection_test;
    import spp_pkg::*;
    // Short busy counts keep the run brief
    localparam int P_CNT = 20;
    localparam int E_CNT = 40;
    logic        hclk;
    logic        hresetn;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        region_protected;
    int          num_errors = 0;
    int          n_compared = 0;
    int          cyc = 0;

    spp_core #(.PROG_CNT(P_CNT), .ERASE_CNT(E_CNT)) spp_core_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .region_protected(region_protected));
    spp_host spp_host_i (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

    // Clock and cycle count
    initial hclk = 1'b0;
    always #4 hclk = ~hclk;
    always @(negedge hclk) cyc++;  // Off the sampling edge, so tasks never race it

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        spp_host_i.xfer(1'b1, a, d, q);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        spp_host_i.xfer(1'b0, a, 32'h0, q);
    endtask : rd

    // Poll busy; polling adds up to two cycles of slack
    task automatic wait_idle(input int t0, output int n);
        logic [31:0] s;
        s = 32'h1;
        for (int i = 0; i < 100 && s[ST_BUSY] !== 1'b0; i++)
            rd(REG_STATUS, s);
        n = cyc - t0;
    endtask : wait_idle

    task automatic read_bit(input int idx, output logic b);
        logic [31:0] s;
        wr(REG_ADDR, spp_host_i.region_base(idx));
        wr(REG_CMD, {29'h0, CMD_READ});
        rd(REG_STATUS, s);
        chk(s[ST_RVALID], 1'b0);
        for (int i = 0; i < 20 && s[ST_RVALID] !== 1'b1; i++)
            rd(REG_STATUS, s);
        rd(REG_RDATA, s);
        b = s[0];
    endtask : read_bit

    task automatic cmd_at(input int idx, input logic [2:0] c, output int t0);
        wr(REG_ADDR, spp_host_i.region_base(idx));
        wr(REG_CMD, {29'h0, c});
        t0 = cyc;
    endtask : cmd_at

    task automatic t_delivered;
        logic b;
        int   idx[4] = '{0, 253, 254, 285};
        foreach (idx[i])
        begin
            read_bit(idx[i], b);
            chk(b, PPB_ERASED_VAL);
        end
    endtask : t_delivered

    task automatic t_program;
        logic [31:0] s;
        logic        b;
        int          t0;
        int          n;
        cmd_at(5, CMD_PROG, t0);
        wr(REG_CMD, {29'h0, CMD_ERASE});
        rd(REG_STATUS, s);
        chk(s[ST_BUSY], 1'b1);
        rd(REG_ARRAYRD, s);
        chk(s[0], 1'b1);
        // The array-read check command latches the refusal into status
        wr(REG_CMD, {29'h0, CMD_ARRAYCHK});
        rd(REG_STATUS, s);
        chk(s[ST_ARRBLK], 1'b1);
        wait_idle(t0, n);
        chk(n >= P_CNT && n <= P_CNT + 6, 1'b1);
        rd(REG_ARRAYRD, s);
        chk(s[0], 1'b0);
        wr(REG_CMD, {29'h0, CMD_ARRAYCHK});
        rd(REG_STATUS, s);
        chk(s[ST_ARRBLK], 1'b0);
        read_bit(5, b);
        chk(b, 1'b0);
        read_bit(6, b);
        chk(b, 1'b1);
        cmd_at(270, CMD_PROG, t0);
        wait_idle(t0, n);
        read_bit(270, b);
        chk(b, 1'b0);
        read_bit(254, b);
        chk(b, 1'b1);
        wr(REG_ADDR, spp_host_i.region_base(5));
        repeat (2) @(posedge hclk);
        chk(region_protected, 1'b1);
    endtask : t_program

    task automatic t_dynamic;
        logic [31:0] s;
        wr(REG_ADDR, spp_host_i.region_base(7));
        rd(REG_ADDR, s);
        chk(s, spp_host_i.region_base(7));
        wr(REG_DYN, 32'h0);
        rd(REG_DYN, s);
        chk(s[0], 1'b0);
        repeat (2) @(posedge hclk);
        chk(region_protected, 1'b1);
        wr(REG_DYN, 32'h1);
        repeat (2) @(posedge hclk);
        chk(region_protected, 1'b0);
    endtask : t_dynamic

    // Erase with an unrelated address still clears every bit
    task automatic t_erase;
        logic b;
        int   t0;
        int   n;
        cmd_at(100, CMD_ERASE, t0);
        wait_idle(t0, n);
        chk(n >= E_CNT && n <= E_CNT + 6, 1'b1);
        read_bit(5, b);
        chk(b, 1'b1);
        read_bit(270, b);
        chk(b, 1'b1);
    endtask : t_erase

    task automatic t_lock;
        logic [31:0] s;
        logic        b;
        int          t0;
        int          n;
        // A programmed bit first, so that a refused erase can be seen
        cmd_at(20, CMD_PROG, t0);
        wait_idle(t0, n);
        rd(REG_STATUS, s);
        chk(s[ST_LOCK], LOCK_RESET_VAL);
        wr(REG_CMD, {29'h0, CMD_LOCK});
        cmd_at(9, CMD_PROG, t0);
        rd(REG_STATUS, s);
        chk({s[ST_LOCK], s[ST_FAIL], s[ST_BUSY]}, 3'b010);
        read_bit(9, b);
        chk(b, 1'b1);
        cmd_at(20, CMD_ERASE, t0);
        rd(REG_STATUS, s);
        chk({s[ST_FAIL], s[ST_BUSY]}, 2'b10);
        wait_idle(t0, n);
        read_bit(20, b);
        chk(b, 1'b0);
        wr(8'h20, 32'hFFFF_FFFF);
        rd(8'h20, s);
        chk(s, 32'h0);
        chk(hresp, 1'b0);
    endtask : t_lock

    task automatic test_done;
        $display("compared %0d, errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : test_done

    // Main sequence after a 16 cycle reset
    initial
    begin
        hresetn = 1'b0;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_delivered();
        t_program();
        t_dynamic();
        t_erase();
        t_lock();
        test_done();
    end

    // Watchdog far beyond the few hundred cycles the run needs
    initial
    begin
        repeat (20000) @(posedge hclk);
        num_errors++;
        test_done();
    end
endmodule : sector_persistent_protection_test
